/* File: hw/tef_pkg.sv */
// holds the constants and carrier types of the top-level event flag block
// assumes one 100 MHz clock and a byte-wide register port at the printed offsets
package tef_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] TEF_OFF_RESET = 8'h1F;
   localparam logic [7:0] TEF_OFF_TOP1 = 8'h20;
   localparam logic [7:0] TEF_OFF_TOP2 = 8'h21;
   localparam logic [7:0] TEF_OFF_BUCK = 8'h22;
   localparam logic [7:0] TEF_OFF_BOOST = 8'h23;
   localparam logic [7:0] TEF_OFF_DIAG = 8'h24;
   localparam logic [7:0] TEF_OFF_STAT = 8'h25;

   // ****************************************
   // field positions
   // ****************************************
   localparam int TEF_B_MEAS = 7;
   localparam int TEF_B_DIAG = 6;
   localparam int TEF_B_BOOST = 5;
   localparam int TEF_B_BUCK = 4;
   localparam int TEF_B_SYNC = 3;
   localparam int TEF_B_SD = 2;
   localparam int TEF_B_WARN = 1;
   localparam int TEF_B_OVP = 0;
   localparam int TEF_B_RSTEVT = 0;
   localparam int TEF_B_SWRST = 0;

   // ****************************************
   // reset values and implemented-bit masks
   // ****************************************
   localparam logic [7:0] TEF_RST_BYTE = 8'h00;
   localparam logic [7:0] TEF_MASK_BUCK = 8'h77;
   localparam logic [7:0] TEF_MASK_BOOST = 8'h07;
   localparam logic [7:0] TEF_MASK_DIAG = 8'h15;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tef_req_t;

   typedef struct packed {
      logic meas_done;
      logic sync_valid;
      logic tdie_sd;
      logic tdie_warn;
      logic ovp;
      logic analog_supply_uv;
      logic [7:0] buck;
      logic [7:0] boost;
      logic [7:0] diag;
   } tef_evt_t;

   typedef struct packed {
      logic [7:0] top1;
      logic rst_evt;
      logic [7:0] buck;
      logic [7:0] boost;
      logic [7:0] diag;
      logic sw_rst_cmd;
      logic sync_prev;
      logic warn_blk;
      logic sync_stat;
      logic sd_stat;
      logic warn_stat;
      logic ovp_stat;
      logic busy;
      logic conv_en;
      logic startup_req;
      logic otp_reload;
      logic [7:0] rdata;
   } tef_state_t;

endpackage

/* File: hw/tef_top.sv */
// top-level event flags: latched top flags, reset-event flag, sub-registers and summaries
// assumes event inputs synchronous to core_clk and one-cycle register strobes
`timescale 1ns/10ps

// Notes on behaviour
// - Measurement-done sets bit 7 of the top flags; a written 1 or a reset cause clears it.
// - Bit 6 mirrors a non-zero diagnostic flag register and drops once it is zero.
// - Bit 5 mirrors a non-zero boost flag register and drops once it is zero.
// - Bit 4 mirrors a non-zero buck flag register for either converter and drops at zero.
// - Bit 3 latches every valid/invalid change of the external clock and clears on a written 1.
// - Over-temperature latches bit 2, turns converters off and keeps them off while it stays set.
// - Clearing bit 2 lets converters run again and also clears the live warning status.
// - Warning temperature latches bit 1, the live warning sits in a status bit, a written 1 clears.
// - Input overvoltage latches bit 0, the live state sits in a status bit, a written 1 clears.
// - Supply undervoltage or a software reset latches bit 0 of the second flag register.
// - Either reset cause turns converters off, restores defaults and starts up, flag left set.
// - Writing 1 to the reset command bit outside an undervoltage cycle resets registers, reloads the OTP and self-clears.
// - Every implemented sub-register bit is a latched event cleared by a written 1 or a reset cause.
module tef_top
   import tef_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire tef_req_t reg_req,
   input wire tef_evt_t evt,
   input wire logic conv_en_req,
   input wire logic startup_done,
   output logic [7:0] reg_rdata,
   output logic conv_en,
   output logic startup_req,
   output logic otp_reload
);

   // ****************************************
   // state
   // ****************************************
   tef_state_t s_ff;
   tef_state_t nxt_s;

   logic [7:0] clr_top1;
   logic [7:0] clr_top2;
   logic [7:0] clr_buck;
   logic [7:0] clr_boost;
   logic [7:0] clr_diag;
   logic sync_edge;
   logic sd_cleared;
   logic rst_cause;
   logic [7:0] set_top1;
   logic [7:0] top1_upd;
   logic rst_upd;
   logic [7:0] buck_upd;
   logic [7:0] boost_upd;
   logic [7:0] diag_upd;
   logic [7:0] rd_mux;

   // ****************************************
   // write-one-to-clear decode
   // ****************************************
   always_comb begin
      clr_top1 = TEF_RST_BYTE;
      clr_top2 = TEF_RST_BYTE;
      clr_buck = TEF_RST_BYTE;
      clr_boost = TEF_RST_BYTE;
      clr_diag = TEF_RST_BYTE;
      // writes to read-only or unmapped offsets clear nothing
      if (reg_req.wr) begin
         case (reg_req.addr)
            TEF_OFF_TOP1: begin
               clr_top1 = reg_req.wdata;
            end
            TEF_OFF_TOP2: begin
               clr_top2 = reg_req.wdata;
            end
            TEF_OFF_BUCK: begin
               clr_buck = reg_req.wdata;
            end
            TEF_OFF_BOOST: begin
               clr_boost = reg_req.wdata;
            end
            TEF_OFF_DIAG: begin
               clr_diag = reg_req.wdata;
            end
            default: begin
               clr_top1 = TEF_RST_BYTE;
            end
         endcase
      end
   end

   // ****************************************
   // event set vector and sticky cells
   // ****************************************
   // a clock already valid at reset release counts as one change
   assign sync_edge = evt.sync_valid ^ s_ff.sync_prev;

   // level events keep setting their flag for as long as they stand
   always_comb begin
      set_top1 = TEF_RST_BYTE;
      set_top1[TEF_B_MEAS] = evt.meas_done;
      set_top1[TEF_B_SYNC] = sync_edge;
      set_top1[TEF_B_SD] = evt.tdie_sd;
      set_top1[TEF_B_WARN] = evt.tdie_warn;
      set_top1[TEF_B_OVP] = evt.ovp;
   end

   // summary bits ride along here but are rebuilt in the next-state logic
   tef_sticky #(
      .WIDTH(8)
   ) i_top1 (
      .cur(s_ff.top1),
      .set(set_top1),
      .clr(clr_top1),
      .nxt_bits(top1_upd)
   );

   tef_sticky #(
      .WIDTH(1)
   ) i_rst (
      .cur(s_ff.rst_evt),
      .set(evt.analog_supply_uv),
      .clr(clr_top2[TEF_B_RSTEVT]),
      .nxt_bits(rst_upd)
   );

   // both converters share the buck register; reserved bits stay zero
   tef_sticky #(
      .WIDTH(8),
      .KEEP(TEF_MASK_BUCK)
   ) i_buck (
      .cur(s_ff.buck),
      .set(evt.buck),
      .clr(clr_buck),
      .nxt_bits(buck_upd)
   );

   tef_sticky #(
      .WIDTH(8),
      .KEEP(TEF_MASK_BOOST)
   ) i_boost (
      .cur(s_ff.boost),
      .set(evt.boost),
      .clr(clr_boost),
      .nxt_bits(boost_upd)
   );

   tef_sticky #(
      .WIDTH(8),
      .KEEP(TEF_MASK_DIAG)
   ) i_diag (
      .cur(s_ff.diag),
      .set(evt.diag),
      .clr(clr_diag),
      .nxt_bits(diag_upd)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nxt_s = s_ff;
      nxt_s.startup_req = 1'b0;
      nxt_s.otp_reload = 1'b0;

      nxt_s.sync_prev = evt.sync_valid;

      // sticky flags come in from the clear/set cells
      nxt_s.top1 = top1_upd;
      nxt_s.rst_evt = rst_upd;
      nxt_s.buck = buck_upd;
      nxt_s.boost = boost_upd;
      nxt_s.diag = diag_upd;

      // live status; a cleared shutdown hides the warning until it drops
      sd_cleared = clr_top1[TEF_B_SD] & s_ff.top1[TEF_B_SD] & ~evt.tdie_sd;
      if (sd_cleared) begin
         nxt_s.warn_blk = 1'b1;
      end else if (!evt.tdie_warn) begin
         nxt_s.warn_blk = 1'b0;
      end
      nxt_s.warn_stat = evt.tdie_warn & ~nxt_s.warn_blk;
      nxt_s.sd_stat = evt.tdie_sd;
      nxt_s.ovp_stat = evt.ovp;
      nxt_s.sync_stat = evt.sync_valid;

      // software reset command, acted on one cycle after the write
      if (reg_req.wr && reg_req.addr == TEF_OFF_RESET && reg_req.wdata[TEF_B_SWRST]) begin
         nxt_s.sw_rst_cmd = 1'b1;
      end

      // after a reset cause, converters stay off until startup reports done
      if (startup_done) begin
         nxt_s.busy = 1'b0;
      end

      // a reset cause wipes events that arrive in the same cycle
      rst_cause = s_ff.sw_rst_cmd | evt.analog_supply_uv;
      if (rst_cause) begin
         nxt_s.top1 = TEF_RST_BYTE;
         nxt_s.buck = TEF_RST_BYTE;
         nxt_s.boost = TEF_RST_BYTE;
         nxt_s.diag = TEF_RST_BYTE;
         nxt_s.warn_blk = 1'b0;
         nxt_s.warn_stat = evt.tdie_warn;
         nxt_s.sw_rst_cmd = 1'b0;
         nxt_s.rst_evt = 1'b1;
         nxt_s.busy = 1'b1;
         nxt_s.startup_req = 1'b1;
         nxt_s.otp_reload = s_ff.sw_rst_cmd;
      end

      // summaries follow the sub-registers as they will stand
      nxt_s.top1[TEF_B_DIAG] = |nxt_s.diag;
      nxt_s.top1[TEF_B_BOOST] = |nxt_s.boost;
      nxt_s.top1[TEF_B_BUCK] = |nxt_s.buck;

      // shutdown flag gates enables; dropping it lets the request through again
      nxt_s.conv_en = conv_en_req & ~nxt_s.top1[TEF_B_SD] & ~nxt_s.busy & ~rst_cause;

      if (reg_req.rd) begin
         nxt_s.rdata = rd_mux;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   // the mux looks at the state before this cycle's write, so a read
   // in the same cycle as a clear still returns the old flags
   always_comb begin
      rd_mux = TEF_RST_BYTE;
      case (reg_req.addr)
         TEF_OFF_RESET: begin
            rd_mux = {7'h00, s_ff.sw_rst_cmd};
         end
         TEF_OFF_TOP1: begin
            rd_mux = s_ff.top1;
         end
         TEF_OFF_TOP2: begin
            rd_mux = {7'h00, s_ff.rst_evt};
         end
         TEF_OFF_BUCK: begin
            rd_mux = s_ff.buck;
         end
         TEF_OFF_BOOST: begin
            rd_mux = s_ff.boost;
         end
         TEF_OFF_DIAG: begin
            rd_mux = s_ff.diag;
         end
         TEF_OFF_STAT: begin
            rd_mux = {4'h0, s_ff.sync_stat, s_ff.sd_stat, s_ff.warn_stat, s_ff.ovp_stat};
         end
         default: begin
            rd_mux = TEF_RST_BYTE;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign reg_rdata = s_ff.rdata;
   assign conv_en = s_ff.conv_en;
   assign startup_req = s_ff.startup_req;
   assign otp_reload = s_ff.otp_reload;

endmodule // tef_top

// ****************************************
// sticky bit cell
// ****************************************
// one cell per register keeps the clear/set ordering in one place;
// set is ORed after the clear, so an event in the clearing cycle wins
module tef_sticky
   import tef_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] KEEP = '1
)
(
   input wire logic [WIDTH-1:0] cur,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   output logic [WIDTH-1:0] nxt_bits
);

   // bits outside KEEP are unimplemented and read back as zero
   assign nxt_bits = ((cur & ~clr) | set) & KEEP;

endmodule // tef_sticky

/* File: dv/tef_top_chk.sv */
// assertions on the event flag block ports
// bound onto tef_top, one clock domain
`timescale 1ns/10ps
module tef_top_chk
   import tef_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire tef_req_t reg_req,
   input wire tef_evt_t evt,
   input wire logic conv_en_req,
   input wire logic [7:0] reg_rdata,
   input wire logic conv_en,
   input wire logic startup_req,
   input wire logic otp_reload
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_en; conv_en |-> $past(conv_en_req); endproperty
   a_en: assert property (p_en) else $error("enable without request");
   property p_sd; evt.tdie_sd |=> !conv_en; endproperty
   a_sd: assert property (p_sd) else $error("enable during shutdown");
   property p_uv; evt.analog_supply_uv |=> startup_req && !conv_en; endproperty
   a_uv: assert property (p_uv) else $error("no startup after undervoltage");
   property p_sw; (reg_req.wr && reg_req.addr == TEF_OFF_RESET && reg_req.wdata[TEF_B_SWRST] && !evt.analog_supply_uv)
      ##1 !evt.analog_supply_uv |=> otp_reload; endproperty
   a_sw: assert property (p_sw) else $error("no reload after reset command");
   property p_otp; otp_reload |-> startup_req && !conv_en; endproperty
   a_otp: assert property (p_otp) else $error("reload without startup");
   property p_ovp; (evt.ovp && !evt.analog_supply_uv) ##1 (evt.ovp && reg_req.rd && reg_req.addr == TEF_OFF_STAT)
      |=> reg_rdata[0]; endproperty
   a_ovp: assert property (p_ovp) else $error("overvoltage status missing");
   property p_meas; (evt.meas_done && !evt.analog_supply_uv) ##1 (reg_req.rd && reg_req.addr == TEF_OFF_TOP1)
      |=> reg_rdata[7]; endproperty
   a_meas: assert property (p_meas) else $error("measurement flag missing");
   property p_rsv; reg_req.rd && reg_req.addr == TEF_OFF_TOP2 |=> reg_rdata[7:1] == 7'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // tef_top_chk
bind tef_top tef_top_chk i_chk (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .evt(evt),
   .conv_en_req(conv_en_req), .reg_rdata(reg_rdata), .conv_en(conv_en), .startup_req(startup_req),
   .otp_reload(otp_reload));

/* File: dv/tb_top_level_event_flags.sv */
// self-checking bench for the event flag block
// assumes tef_pkg, tef_top and the checker compiled first
`timescale 1ns/10ps
module tb_top_level_event_flags
   import tef_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic conv_en_req = 1'b0;
   logic startup_done = 1'b0;
   tef_req_t reg_req = '0;
   tef_evt_t evt = '0;
   logic [7:0] reg_rdata;
   logic conv_en;
   logic startup_req;
   logic otp_reload;
   logic [7:0] sv[4] = '{8'h00, 8'h08, 8'h02, 8'h01};
   logic [7:0] fb[4] = '{8'h80, 8'h08, 8'h02, 8'h01};
   logic [7:0] off[3] = '{TEF_OFF_BUCK, TEF_OFF_BOOST, TEF_OFF_DIAG};
   logic [7:0] msk[3] = '{TEF_MASK_BUCK, TEF_MASK_BOOST, TEF_MASK_DIAG};
   logic [7:0] top;
   int n_errors = 0;
   int tests_run = 0;
   int i;
   always #5 core_clk = ~core_clk;
   tef_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .evt(evt),
      .conv_en_req(conv_en_req), .startup_done(startup_done), .reg_rdata(reg_rdata), .conv_en(conv_en),
      .startup_req(startup_req), .otp_reload(otp_reload));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // strobes last one cycle, so back-to-back calls leave a gap
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(negedge core_clk);
      reg_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(negedge core_clk);
      reg_req.rd = 1'b0;
      chk(reg_rdata, e);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_en;
      int k;
      for (k = 0; k < 20 && conv_en !== 1'b1; k++) @(negedge core_clk);
      chk({7'h00, conv_en}, 8'h01);
      if (k == 20) end_of_test;
   endtask
   initial begin
      repeat (8) @(negedge core_clk);
      sys_rst = 1'b0;
      startup_done = 1'b1;
      @(negedge core_clk);
      startup_done = 1'b0;
      rd(TEF_OFF_TOP1, 8'h00);
      rd(TEF_OFF_TOP2, 8'h00);
      rd(8'h30, 8'h00);
      $display("test reset values done");
      for (i = 0; i < 4; i++) begin
         @(negedge core_clk);
         evt = '0;
         case (i)
            0: evt.meas_done = 1'b1;
            1: evt.sync_valid = 1'b1;
            2: evt.tdie_warn = 1'b1;
            default: evt.ovp = 1'b1;
         endcase
         rd(TEF_OFF_STAT, sv[i]);
         // clearing while a level event stands must lose, except the edge-set clock flag (i == 1), which clears
         wr(TEF_OFF_TOP1, fb[i]);
         rd(TEF_OFF_TOP1, (i == 1) ? 8'h00 : fb[i]);
         evt = '0;
         wr(TEF_OFF_TOP1, 8'h00);
         rd(TEF_OFF_TOP1, fb[i]);
         wr(TEF_OFF_TOP1, fb[i]);
         rd(TEF_OFF_TOP1, 8'h00);
      end
      $display("test latched flags done");
      @(negedge core_clk);
      evt.buck = 8'hFF;
      evt.boost = 8'hFF;
      evt.diag = 8'hFF;
      @(negedge core_clk);
      evt = '0;
      top = 8'h70;
      rd(TEF_OFF_TOP1, top);
      for (i = 0; i < 3; i++) begin
         rd(off[i], msk[i]);
         wr(off[i], 8'h01);
         rd(off[i], msk[i] & 8'hFE);
         rd(TEF_OFF_TOP1, top);
         wr(off[i], 8'hFF);
         top = top & ~(8'h10 << i);
         rd(TEF_OFF_TOP1, top);
      end
      $display("test summaries done");
      conv_en_req = 1'b1;
      wait_en;
      evt.tdie_sd = 1'b1;
      evt.tdie_warn = 1'b1;
      rd(TEF_OFF_STAT, 8'h06);
      evt.tdie_sd = 1'b0;
      rd(TEF_OFF_TOP1, 8'h06);
      chk({7'h00, conv_en}, 8'h00);
      wr(TEF_OFF_TOP1, 8'h04);
      rd(TEF_OFF_STAT, 8'h00);
      wait_en;
      evt.tdie_warn = 1'b0;
      wr(TEF_OFF_TOP1, 8'h02);
      rd(TEF_OFF_TOP1, 8'h00);
      $display("test thermal done");
      evt.ovp = 1'b1;
      @(negedge core_clk);
      evt.ovp = 1'b0;
      wr(TEF_OFF_RESET, 8'h01);
      @(negedge core_clk);
      chk({5'h00, startup_req, otp_reload, conv_en}, 8'h06);
      @(negedge core_clk);
      chk({5'h00, startup_req, otp_reload, conv_en}, 8'h00);
      rd(TEF_OFF_TOP2, 8'h01);
      rd(TEF_OFF_TOP1, 8'h00);
      rd(TEF_OFF_RESET, 8'h00);
      chk({7'h00, conv_en}, 8'h00);
      startup_done = 1'b1;
      @(negedge core_clk);
      startup_done = 1'b0;
      wait_en;
      wr(TEF_OFF_TOP2, 8'h01);
      rd(TEF_OFF_TOP2, 8'h00);
      evt.analog_supply_uv = 1'b1;
      @(negedge core_clk);
      chk({5'h00, startup_req, otp_reload, conv_en}, 8'h04);
      evt.analog_supply_uv = 1'b0;
      rd(TEF_OFF_TOP2, 8'h01);
      $display("test reset causes done");
      sys_rst = 1'b1;
      @(negedge core_clk);
      chk({5'h00, startup_req, otp_reload, conv_en}, 8'h00);
      sys_rst = 1'b0;
      rd(TEF_OFF_TOP2, 8'h00);
      wait_en;
      $display("test mid-run reset done");
      end_of_test;
   end
endmodule // tb_top_level_event_flags
